//--- wdog_cfg.svh
// constants for the software watchdog with reset-cause recording
// assumes a 32-bit ahb-lite register bus, one word per register
`ifndef WDOG_CFG_SVH
`define WDOG_CFG_SVH
// ========================================
// register byte offsets
`define OFS_RESET_CAUSE   8'h00
`define OFS_CONTROL       8'h04
`define OFS_VECTOR        8'h08
`define OFS_SERVICE       8'h0c
`define OFS_IRQ_CONTROL   8'h10
// ========================================
// field positions
`define BIT_EXT_FLAG      7
`define BIT_WDOG_FLAG     5
`define BIT_ENABLE        7
`define BIT_ACTION        6
`define BIT_PRESCALE      5
`define BIT_TSEL_HI       4
`define BIT_TSEL_LO       3
`define BIT_HANG_EN       2
`define BIT_HANG_DONE     1
// ========================================
// reset values, service keys, prescale divider and reset-out pulse length
`define VECTOR_RST        8'h0f
`define CONTROL_RST       8'h00
`define KEY_ARM           8'h55
`define KEY_FIRE          8'haa
`define PRESCALE_DIV      8192
`define RESET_OUT_CYCLES  16
`endif

//--- wdog_pkg.sv
// types for the software watchdog block
// assumes wdog_cfg.svh is included by the design file
package wdog_pkg;
   // ========================================
   // register bus request as captured in the address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } bus_req_s;
   // watchdog control fields
   typedef struct packed {
      logic       enable;
      logic       action_reset;
      logic       prescale;
      logic [1:0] tsel;
      logic       hang_en;
   } ctrl_s;
endpackage : wdog_pkg

//--- sw_watchdog_reset_status.sv
// software watchdog with reset-cause register, vectored interrupt and hang escape
// assumes a single 100 MHz clock, an ahb-lite slave port and an external reset pin
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "wdog_cfg.svh"
module sw_watchdog_reset_status #(
   parameter int PRESCALE = `PRESCALE_DIV           // count clock divider
) (
   input  wire logic        i_mclk,      // system clock
   input  wire logic        i_nrst,      // synchronous active-low external reset pin
   input  wire logic        i_ce,        // clock enable, freezes state when low
   input  wire logic        hsel,        // ahb slave select
   input  wire logic [31:0] haddr,       // ahb address
   input  wire logic [1:0]  htrans,      // ahb transfer type
   input  wire logic        hwrite,      // ahb write
   input  wire logic [2:0]  hsize,       // ahb size
   input  wire logic [31:0] hwdata,      // ahb write data
   input  wire logic        hready,      // ahb bus ready
   output logic      [31:0] hrdata,      // ahb read data
   output logic             hreadyout,   // ahb slave ready
   output logic             hresp,       // ahb response, always okay
   input  wire logic        i_interrupt_ack_cycle,      // interrupt acknowledge cycle for this source
   output logic      [7:0]  o_vector,    // vector returned in the acknowledge cycle
   output logic             o_autovec,   // autovector request, never asserted
   output logic             o_irq,       // watchdog interrupt pending
   output logic      [7:0]  o_irq_level, // interrupt level field
   output logic             o_soft_rst,  // internal soft reset to other modules
   output logic             o_reset_out_n, // reset output pin, active low
   output logic             o_transfer_ack // transfer acknowledge to end a hung cycle
);
   // ========================================
   // local state
   wdog_pkg::bus_req_s req_r;
   wdog_pkg::ctrl_s    ctrl_r;
   wdog_pkg::ctrl_s    active_r;        // timeout selection in force
   logic [7:0]         cause_r;
   logic [7:0]         vector_r;
   logic [7:0]         irq_ctrl_r;
   logic               hang_done_r;
   logic               armed_r;
   logic               pend_r;
   logic               hang_phase_r;
   logic [28:0]        count_r;
   logic [12:0]        pre_r;
   logic [3:0]         rst_cnt_r;
   logic               soft_rst_r;
   logic               svc;
   logic               tick;
   logic               expire;
   logic               wr_ok;

   // decode a delay selection into its last count value
   function automatic logic [28:0] limit_of(input wdog_pkg::ctrl_s c);
      logic [4:0] sh;
      sh = c.prescale ? 5'd9 : 5'd9;   // count units: prescaled clocks start at 2^9
      sh = 5'(sh + {2'b00, c.tsel, 1'b0});
      return 29'((29'h1 << sh) - 29'h1);
   endfunction : limit_of

   // ========================================
   // bus slave: zero wait states, address phase captured when ready
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wr_ok     = req_r.valid & req_r.write & i_ce;

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         req_r <= '0;
      end else if (i_ce && hready) begin
         req_r.valid <= hsel & htrans[1];
         req_r.write <= hwrite;
         req_r.addr  <= haddr[7:0];
      end
   end

   // read mux, decoded from the registered address phase so data stands in the data phase
   always_comb begin
      hrdata = 32'h0000_0000;
      if (req_r.valid && !req_r.write) begin
         case (req_r.addr)
            `OFS_RESET_CAUSE: hrdata[7:0] = cause_r;
            `OFS_CONTROL:     hrdata[7:0] = {ctrl_r.enable, ctrl_r.action_reset,
                                             ctrl_r.prescale, ctrl_r.tsel,
                                             ctrl_r.hang_en, hang_done_r, 1'b0};
            `OFS_VECTOR:      hrdata[7:0] = vector_r;
            `OFS_IRQ_CONTROL: hrdata[31:24] = irq_ctrl_r;
            default:          hrdata = 32'h0000_0000;
         endcase
      end
   end

   // ========================================
   // control, vector and irq-level registers
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         ctrl_r     <= '0;
         vector_r   <= `VECTOR_RST;
         irq_ctrl_r <= 8'h00;
      end else if (wr_ok) begin
         if (req_r.addr == `OFS_CONTROL && !pend_r) begin
            ctrl_r.enable       <= hwdata[`BIT_ENABLE];
            ctrl_r.action_reset <= hwdata[`BIT_ACTION];
            ctrl_r.prescale     <= hwdata[`BIT_PRESCALE];
            ctrl_r.tsel         <= hwdata[`BIT_TSEL_HI:`BIT_TSEL_LO];
            ctrl_r.hang_en      <= hwdata[`BIT_HANG_EN];
         end
         if (req_r.addr == `OFS_VECTOR)
            vector_r <= hwdata[7:0];
         if (req_r.addr == `OFS_IRQ_CONTROL)
            irq_ctrl_r <= hwdata[31:24];
      end
   end

   // ========================================
   // service sequence: arm on 0x55, fire on 0xaa only when armed
   assign svc = wr_ok && req_r.addr == `OFS_SERVICE &&
                hwdata[7:0] == `KEY_FIRE && armed_r;

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         armed_r <= 1'b0;
      end else if (wr_ok && req_r.addr == `OFS_SERVICE) begin
         if (hwdata[7:0] == `KEY_ARM)
            armed_r <= 1'b1;
         else if (hwdata[7:0] == `KEY_FIRE)
            armed_r <= 1'b0;
      end
   end

   // selection in force is latched only on a full service
   always_ff @(posedge i_mclk) begin
      if (!i_nrst)
         active_r <= '0;
      else if (svc)
         active_r <= ctrl_r;
   end

   // ========================================
   // prescaler: 8192 clocks per tick when selected
   assign tick = active_r.prescale ? (pre_r == 13'(PRESCALE - 1)) : 1'b1;

   always_ff @(posedge i_mclk) begin
      if (!i_nrst || svc)
         pre_r <= 13'h0000;
      else if (i_ce && ctrl_r.enable)
         pre_r <= tick ? 13'h0000 : 13'(pre_r + 13'h0001);
   end

   // up-counter from zero; prescaled steps add 13 to the exponent (9+13=22)
   assign expire = ctrl_r.enable && tick && count_r == limit_of(active_r);

   always_ff @(posedge i_mclk) begin
      if (!i_nrst || svc)
         count_r <= 29'h0;
      else if (i_ce && ctrl_r.enable && tick)
         count_r <= expire ? 29'h0 : 29'(count_r + 29'h1);
   end

   // ========================================
   // interrupt pending and hang escape
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         pend_r       <= 1'b0;
         hang_phase_r <= 1'b0;
      end else if (i_ce) begin
         if (i_interrupt_ack_cycle && pend_r) begin
            pend_r       <= 1'b0;
            hang_phase_r <= 1'b0;
         end else if (expire && !active_r.action_reset) begin
            pend_r       <= 1'b1;
            hang_phase_r <= pend_r;
         end
      end
   end

   assign o_irq          = pend_r;
   assign o_irq_level    = irq_ctrl_r;
   assign o_vector       = vector_r;
   assign o_autovec      = 1'b0;
   assign o_transfer_ack = hang_phase_r & pend_r & ctrl_r.hang_en;

   // done flag: hardware set wins over software clear
   always_ff @(posedge i_mclk) begin
      if (!i_nrst)
         hang_done_r <= 1'b0;
      else if (i_ce) begin
         if (o_transfer_ack)
            hang_done_r <= 1'b1;
         else if (wr_ok && req_r.addr == `OFS_CONTROL && hwdata[`BIT_HANG_DONE])
            hang_done_r <= 1'b0;
      end
   end

   // ========================================
   // reset-mode timeout: soft reset pulse stretched so peers see it
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         rst_cnt_r  <= 4'h0;
         soft_rst_r <= 1'b0;
      end else if (i_ce) begin
         if (expire && active_r.action_reset) begin
            soft_rst_r <= 1'b1;
            rst_cnt_r  <= 4'(`RESET_OUT_CYCLES - 1);
         end else if (rst_cnt_r != 4'h0)
            rst_cnt_r <= 4'(rst_cnt_r - 4'h1);
         else
            soft_rst_r <= 1'b0;
      end
   end

   assign o_soft_rst    = soft_rst_r;
   assign o_reset_out_n = ~soft_rst_r;

   // cause register: exactly one flag after each reset
   always_ff @(posedge i_mclk) begin
      if (!i_nrst)
         cause_r <= 8'h80;
      else if (i_ce && expire && active_r.action_reset)
         cause_r <= 8'h20;
   end

   // ========================================
   // checks
   AST_CAUSE_ONEHOT: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      $onehot({cause_r[`BIT_EXT_FLAG], cause_r[`BIT_WDOG_FLAG]}))
      else $error("cause flags not one-hot");
   AST_DISABLED_HOLD: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      !ctrl_r.enable && !svc |=> $stable(count_r))
      else $error("counter moved while disabled");
   AST_INTERRUPT_ACK_CYCLE_CLEARS: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      i_ce && i_interrupt_ack_cycle && pend_r |=> !pend_r)
      else $error("acknowledge did not clear pending");
   AST_SVC_KEEPS_IRQ: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      pend_r && !i_interrupt_ack_cycle |=> pend_r)
      else $error("pending cleared without acknowledge");
   AST_CTRL_LOCK: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      pend_r |=> $stable(ctrl_r))
      else $error("control changed while pending");
   AST_SVC_RESTART: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      svc |=> count_r == 29'h0)
      else $error("service did not restart count");
   AST_RESET_PIN: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      i_ce && expire && active_r.action_reset |=> !o_reset_out_n && cause_r == 8'h20)
      else $error("reset timeout not signalled");
   AST_TA_FLAG: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      i_ce && o_transfer_ack |=> hang_done_r)
      else $error("done flag not set");
   AST_NO_AUTOVEC: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      !o_autovec && (o_vector == vector_r))
      else $error("autovector used");
endmodule : sw_watchdog_reset_status

//--- wdog_core_model.sv
// core-side model: runs the interrupt acknowledge cycle for the watchdog source
// assumes the bench gates it with i_en and reads back the vector it captured
`timescale 1ns/10ps
module wdog_core_model #(
   parameter int DLY = 3                   // cycles between seeing irq and acknowledging
) (
   input  wire logic       i_mclk,         // system clock
   input  wire logic       i_nrst,         // sync active-low reset
   input  wire logic       i_en,           // bench lets the core acknowledge
   input  wire logic       i_irq,          // pending watchdog interrupt
   input  wire logic [7:0] i_vec,          // vector driven by the block
   output logic            o_interrupt_ack_cycle,         // acknowledge cycle running
   output logic      [7:0] o_seen          // vector taken during the cycle
);
   int cnt;
   // ========================================
   // acknowledge after a delay, hold until the source drops its request
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         cnt    <= 0;
         o_interrupt_ack_cycle <= 1'b0;
         o_seen <= 8'h00;
      end else if (o_interrupt_ack_cycle) begin
         if (!i_irq) o_interrupt_ack_cycle <= 1'b0;
         else o_seen <= i_vec;             // vector read inside the cycle, no autovector
      end else if (i_en && i_irq) begin
         if (cnt == DLY) begin
            o_interrupt_ack_cycle <= 1'b1;
            cnt    <= 0;
         end else cnt <= cnt + 1;
      end else cnt <= 0;
   end
endmodule : wdog_core_model

//--- sw_watchdog_reset_status_test.sv
// self-checking bench for the watchdog block over its ahb-lite port
// assumes PRESCALE shrunk to 4 so prescaled timeouts stay short
`timescale 1ns/10ps
`include "wdog_cfg.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
   $display("BAD %s exp %h got %h", nm, ex, got); end end
module sw_watchdog_reset_status_test;
   logic        i_mclk, i_nrst, hsel, hwrite, pen, interrupt_ack_cycle, autovec, irq, srst, rst_n, tack;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [7:0]  vec, lvl, seen;
   logic        hrdy, hresp;
   int          bad_count, n_tests;
   sw_watchdog_reset_status #(.PRESCALE(4)) uut (.i_mclk(i_mclk), .i_nrst(i_nrst),
      .i_ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
      .hresp(hresp), .i_interrupt_ack_cycle(interrupt_ack_cycle), .o_vector(vec), .o_autovec(autovec), .o_irq(irq),
      .o_irq_level(lvl), .o_soft_rst(srst), .o_reset_out_n(rst_n), .o_transfer_ack(tack));
   wdog_core_model core (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_en(pen), .i_irq(irq),
      .i_vec(vec), .o_interrupt_ack_cycle(interrupt_ack_cycle), .o_seen(seen));
   // ========================================
   // clock and hang guard; the longest test run is well under 30k cycles
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   initial begin
      #300us;
      bad_count++;
      wrap_up();
   end
   // ========================================
   // bus tasks: address phase held until hready, then data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge i_mclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge i_mclk); while (hrdy !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge i_mclk); while (hrdy !== 1'b1);
      q = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      `CHK(nm, ex, q)
   endtask : rd
   task automatic service();
      wr(`OFS_SERVICE, 32'h55);
      wr(`OFS_SERVICE, 32'haa);
   endtask : service
   task automatic idle(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : idle
   // waits a bounded time for irq (0), transfer ack (1) or reset out low (2)
   task automatic wait_sig(input int sel, input int n);
      for (int i = 0; i < n; i++) begin
         if ((sel == 0 && irq) || (sel == 1 && tack) || (sel == 2 && !rst_n)) break;
         @(posedge i_mclk);
      end
   endtask : wait_sig
   // nothing before lo cycles, the interrupt by hi cycles; then acknowledge it
   task automatic window(input string nm, input int lo, input int hi);
      idle(lo);
      `CHK(nm, 1'b0, irq)
      wait_sig(0, hi - lo);
      `CHK(nm, 1'b1, irq)
      pen <= 1'b1;
      idle(20);
      pen <= 1'b0;
   endtask : window
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // ========================================
   // test sequence
   initial begin
      {i_nrst, hsel, hwrite, pen, htrans, haddr, hwdata} = '0;
      bad_count = 0;
      n_tests   = 0;
      idle(6);
      i_nrst <= 1'b1;
      rd("cause", `OFS_RESET_CAUSE, 32'h80);
      rd("control", `OFS_CONTROL, 32'h00);
      rd("vector", `OFS_VECTOR, 32'h0f);
      rd("unmapped", 8'h20, 32'h00);
      $display("test reset values done");
      wr(`OFS_IRQ_CONTROL, 32'h05000000);
      wr(`OFS_VECTOR, 32'h42);
      idle(1500);
      `CHK("irq off", 1'b0, irq)
      `CHK("level", 8'h05, lvl)
      rd("vector", `OFS_VECTOR, 32'h42);
      $display("test disabled hold done");
      wr(`OFS_CONTROL, 32'h80);
      idle(300);
      wr(`OFS_SERVICE, 32'h55);
      wr(`OFS_SERVICE, 32'h11);
      wr(`OFS_SERVICE, 32'haa);
      idle(300);
      `CHK("restart", 1'b0, irq)
      wr(`OFS_SERVICE, 32'haa);
      idle(300);
      `CHK("lone key", 1'b1, irq)
      wr(`OFS_CONTROL, 32'h00);
      rd("locked", `OFS_CONTROL, 32'h80);
      service();
      `CHK("kept", 1'b1, irq)
      pen <= 1'b1;
      idle(20);
      pen <= 1'b0;
      `CHK("vector seen", 8'h42, seen)
      `CHK("autovec", 1'b0, autovec)
      `CHK("acked", 1'b0, irq)
      wr(`OFS_CONTROL, 32'h00);
      $display("test service done");
      service();
      wr(`OFS_CONTROL, 32'h80);
      wr(`OFS_CONTROL, 32'h88);
      window("old period", 400, 700);
      wr(`OFS_CONTROL, 32'h08);
      service();
      wr(`OFS_CONTROL, 32'h88);
      window("tsel one", 1800, 2400);
      wr(`OFS_CONTROL, 32'h20);
      service();
      wr(`OFS_CONTROL, 32'ha0);
      window("prescaled", 1800, 2400);
      wr(`OFS_CONTROL, 32'h04);
      service();
      wr(`OFS_CONTROL, 32'h84);
      wait_sig(0, 700);
      `CHK("irq", 1'b1, irq)
      wait_sig(1, 700);
      `CHK("hang ack", 1'b1, tack)
      rd("done flag", `OFS_CONTROL, 32'h86);
      pen <= 1'b1;
      idle(20);
      pen <= 1'b0;
      `CHK("hang ack off", 1'b0, tack)
      wr(`OFS_CONTROL, 32'h02);
      rd("flag clear", `OFS_CONTROL, 32'h00);
      $display("test timeouts done");
      wr(`OFS_CONTROL, 32'h40);
      service();
      wr(`OFS_CONTROL, 32'hc0);
      wait_sig(2, 700);
      `CHK("reset out", 1'b0, rst_n)
      `CHK("soft reset", 1'b1, srst)
      `CHK("no irq", 1'b0, irq)
      idle(20);
      rd("cause", `OFS_RESET_CAUSE, 32'h20);
      i_nrst <= 1'b0;
      idle(2);
      i_nrst <= 1'b1;
      rd("cause", `OFS_RESET_CAUSE, 32'h80);
      rd("control", `OFS_CONTROL, 32'h00);
      $display("test reset mode done");
      wrap_up();
   end
endmodule : sw_watchdog_reset_status_test
